//--- rtl/charge_cfg.svh
// Purpose: Constants for the charge cycle sequencer.
// Assumes: A 25 MHz system clock.
// Notes:   Flash and blank cycle counts are derived from the times in their own units.
`ifndef CHARGE_CFG_SVH
`define CHARGE_CFG_SVH
`define CLK_HZ            25000000
`define FLASH_HALF_NS     166666666
`define FLASH_HALF_CYC    ((`FLASH_HALF_NS / 40) > 0 ? (`FLASH_HALF_NS / 40) : 1)
`define BLANK_MS          750
`define BLANK_CYC         ((`BLANK_MS * (`CLK_HZ / 1000)))
`define QUAL1_TIMEOUT_CYC 25000000
`define QUAL2_TIMEOUT_CYC 25000000
`define HOLDOFF_CYC       2500000
`define PULSE_PERIOD_CYC  25000
`define PULSE_ON_CYC      2500
`endif

//--- rtl/charge_cycle_sequencer.sv
// Purpose: Charge cycle sequencer for a lead-acid battery charger.
// Assumes: Comparator flags are asynchronous; one 25 MHz clock.
// Notes:   Analog regulation, thresholds and the PWM timebase live outside.
//
// What this block does
// - Two select pins choose two-step voltage, two-step current or pulsed current.
// - Start a cycle on power-up with battery present or on insertion.
// - At cycle start, bad or missing temperature sends the cycle to pending.
// - Temperature is watched all cycle, except while in the fault state.
// - Pending freezes the shared phase timer without clearing it; flash and pulse counters run on.
// - Temperature back in range resumes the interrupted state, or test one if parked at cycle start.
// - Test one: regulate float plus margin; no conditioning current by timeout faults.
// - Then regulate conditioning current; cell below float by timeout faults.
// - Test two pass is ignored during hold-off; pass goes to fast charge.
// - Fault holds until power cycle or insertion, then qualification restarts.
// - Two-step voltage phase one: max current until bulk level.
// - Phase two: bulk voltage until minimum current, then float voltage.
// - Two-step current: max current until bulk or second difference trips.
// - Pulsed current: max until bulk, then hysteretic float/bulk on-off.
// - Display select low, high or floating picks lamp mode one, two, three.
// - Battery absent or over-voltage shows lamp three only.
// - Modes one and two lamp patterns for qualify, fast and maintain.
// - Mode three patterns, with current and voltage fast charge distinguished.
// - Fault lights lamp three, pending flashes it; lamps one, two hold.
// - Flash is one sixth second low, one sixth high; lamps drive both levels.
// - Pulsed current shows fast when current on, maintenance when off.
// - Current gate high lets current flow, low blocks it.
// - Battery present inside cutoff window; entry is insertion, exit faults.
// - Latch selects on supply valid, fault exit, insertion; blank lamps 750 ms.
`timescale 1ns/1ps
`default_nettype none
`include "charge_cfg.svh"
module charge_cycle_sequencer #(
    parameter int QUAL1_TIMEOUT = `QUAL1_TIMEOUT_CYC,
    parameter int QUAL2_TIMEOUT = `QUAL2_TIMEOUT_CYC,
    parameter int HOLDOFF       = `HOLDOFF_CYC,
    parameter int FLASH_HALF    = `FLASH_HALF_CYC,
    parameter int BLANK_TIME    = `BLANK_CYC,
    parameter int PULSE_PERIOD  = `PULSE_PERIOD_CYC,
    parameter int PULSE_ON      = `PULSE_ON_CYC
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             supply_valid,
    input  wire logic             above_low_cutoff,
    input  wire logic             below_high_cutoff,
    input  wire logic             temp_in_range,
    input  wire logic             current_at_cond,
    input  wire logic             cell_at_float,
    input  wire logic             batt_at_bulk,
    input  wire logic             batt_at_float,
    input  wire logic             current_at_min,
    input  wire logic             second_diff_trip,
    input  wire logic             pwm_gate,
    input  wire logic             algo_select_a,
    input  wire logic             algo_select_b,
    input  wire logic             display_select_high,
    input  wire logic             display_select_low,
    output logic                  current_gate,
    output charge_pkg::reg_type   reg_mode,
    output charge_pkg::level_type voltage_level,
    output charge_pkg::cur_type   current_level,
    output logic                  status_lamp_1,
    output logic                  status_lamp_2,
    output logic                  status_lamp_3,
    output logic                  lamp_enable_n
);
    typedef enum logic [3:0] {
        ST_START, ST_PENDING, ST_QUAL1, ST_QUAL2, ST_FAULT,
        ST_FAST1, ST_FAST2, ST_MAINT
    } state_type;

    localparam int NFLAGS = 13;

    // ----------------------------------------
    // Input synchronisation
    // ----------------------------------------
    logic [NFLAGS-1:0] raw_flags;
    logic [NFLAGS-1:0] flags;
    assign raw_flags = {supply_valid, above_low_cutoff, below_high_cutoff, temp_in_range,
                        current_at_cond, cell_at_float, batt_at_bulk, batt_at_float,
                        current_at_min, second_diff_trip, algo_select_a, algo_select_b,
                        display_select_high};
    sync_flags #(.WIDTH(NFLAGS)) u_sync (
        .clk      (clk),
        .rst      (rst),
        .async_in (raw_flags),
        .sync_out (flags)
    );
    logic disp_low_meta;
    logic disp_low_s;
    always_ff @(posedge clk) begin
        disp_low_meta <= rst ? 1'b0 : display_select_low;
        disp_low_s    <= rst ? 1'b0 : disp_low_meta;
    end

    wire s_supply  = flags[12];
    wire s_in_win  = flags[11] & flags[10];
    wire s_temp_ok = flags[9];
    wire s_cond    = flags[8];
    wire s_cellflt = flags[7];
    wire s_bulk    = flags[6];
    wire s_bflt    = flags[5];
    wire s_imin    = flags[4];
    wire s_d2v     = flags[3];
    wire s_sel_a   = flags[2];
    wire s_sel_b   = flags[1];
    wire s_dhigh   = flags[0];

    // ----------------------------------------
    // State registers
    // ----------------------------------------
    state_type            state;
    state_type            resume_state;
    charge_pkg::algo_type algo;
    charge_pkg::disp_type disp;
    logic                 present;
    logic                 supply_d;
    logic [31:0]          timer;
    logic [31:0]          blank_cnt;
    logic [31:0]          flash_cnt;
    logic                 flash;
    logic [31:0]          pulse_cnt;
    logic                 pulse_on_phase;
    logic                 maint_on;
    logic                 lamp_hold_1;
    logic                 lamp_hold_2;

    // Presence window edges: entry is insertion, exit is removal.
    wire insertion   = s_in_win & ~present;
    wire removal     = ~s_in_win & present;
    wire power_up    = s_supply & ~supply_d;
    wire start_cycle = insertion | (power_up & s_in_win);
    wire latch_now   = power_up | insertion;
    wire temp_bad    = ~s_temp_ok;

    // Selection decode is continuous so the latch below stays a plain copy.
    charge_pkg::algo_type sel_algo;
    charge_pkg::disp_type sel_disp;
    assign sel_algo = ~s_sel_a ? charge_pkg::ALGO_TWO_STEP_VOLTAGE :
                      s_sel_b  ? charge_pkg::ALGO_PULSED_CURRENT :
                                 charge_pkg::ALGO_TWO_STEP_CURRENT;
    assign sel_disp = s_dhigh    ? charge_pkg::DISP_MODE_2 :
                      disp_low_s ? charge_pkg::DISP_MODE_1 :
                                   charge_pkg::DISP_MODE_3;

    wire timer_run = (state != ST_PENDING);
    wire holdoff_done = (timer >= 32'(HOLDOFF));

    // ----------------------------------------
    // Next-state decode
    // ----------------------------------------
    state_type next_state;
    always_comb begin
        next_state = state;
        unique case (state)
            ST_START:   next_state = temp_bad ? ST_PENDING : ST_QUAL1;
            ST_PENDING: next_state = s_temp_ok ? resume_state : ST_PENDING;
            ST_QUAL1: begin
                if (s_cond)
                    next_state = ST_QUAL2;
                else if (timer >= 32'(QUAL1_TIMEOUT))
                    next_state = ST_FAULT;
            end
            ST_QUAL2: begin
                if (s_cellflt && holdoff_done)
                    next_state = ST_FAST1;
                else if (timer >= 32'(QUAL2_TIMEOUT))
                    next_state = ST_FAULT;
            end
            ST_FAST1: begin
                if (s_bulk && holdoff_done)
                    next_state = (algo == charge_pkg::ALGO_TWO_STEP_VOLTAGE) ?
                                 ST_FAST2 : ST_MAINT;
                else if (algo == charge_pkg::ALGO_TWO_STEP_CURRENT && s_d2v && holdoff_done)
                    next_state = ST_MAINT;
            end
            ST_FAST2:   next_state = s_imin ? ST_MAINT : ST_FAST2;
            ST_MAINT:   next_state = ST_MAINT;
            ST_FAULT:   next_state = ST_FAULT;
        endcase
        // Temperature leaves range: park the cycle, but never from fault.
        if (state != ST_FAULT && state != ST_PENDING && state != ST_START && temp_bad)
            next_state = ST_PENDING;
        if (removal)
            next_state = ST_FAULT;
        if (start_cycle)
            next_state = ST_START;
    end

    // ----------------------------------------
    // Sequencer registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            state        <= ST_FAULT;
            resume_state <= ST_START;
            present      <= 1'b0;
            supply_d     <= 1'b0;
        end else begin
            state    <= next_state;
            present  <= s_in_win;
            supply_d <= s_supply;
            if (next_state == ST_PENDING && state != ST_PENDING)
                resume_state <= (state == ST_START) ? ST_QUAL1 : state;
        end
    end

    // Shared timer restarts on each new phase and holds while pending.
    always_ff @(posedge clk) begin
        if (rst || start_cycle)
            timer <= 32'h0000_0000;
        else if (next_state != state && next_state != ST_PENDING && state != ST_PENDING)
            timer <= 32'h0000_0000;
        else if (timer_run && timer != 32'hFFFF_FFFF)
            timer <= timer + 32'h0000_0001;
    end

    // Select pins are read only at latch events, lamps blank for BLANK_TIME after each.
    always_ff @(posedge clk) begin
        if (rst) begin
            algo      <= charge_pkg::ALGO_TWO_STEP_VOLTAGE;
            disp      <= charge_pkg::DISP_MODE_1;
            blank_cnt <= 32'h0000_0000;
        end else if (latch_now) begin
            algo      <= sel_algo;
            disp      <= sel_disp;
            blank_cnt <= 32'(BLANK_TIME);
        end else if (blank_cnt != 32'h0000_0000) begin
            blank_cnt <= blank_cnt - 32'h0000_0001;
        end
    end

    // Flash toggles every sixth of a second.
    always_ff @(posedge clk) begin
        if (rst || flash_cnt >= 32'(FLASH_HALF - 1)) begin
            flash_cnt <= 32'h0000_0000;
            flash     <= rst ? 1'b0 : ~flash;
        end else begin
            flash_cnt <= flash_cnt + 32'h0000_0001;
        end
    end

    // Fixed maintenance pulse train and the pulsed-current hysteresis.
    always_ff @(posedge clk) begin
        if (rst || pulse_cnt >= 32'(PULSE_PERIOD - 1))
            pulse_cnt <= 32'h0000_0000;
        else
            pulse_cnt <= pulse_cnt + 32'h0000_0001;
        pulse_on_phase <= ~rst && (pulse_cnt < 32'(PULSE_ON));
        if (rst || state != ST_MAINT)
            maint_on <= 1'b0;
        else if (s_bulk)
            maint_on <= 1'b0;
        else if (!s_bflt)
            maint_on <= 1'b1;
    end

    // ----------------------------------------
    // Regulator command decode
    // ----------------------------------------
    wire pulsed  = (algo == charge_pkg::ALGO_PULSED_CURRENT);
    wire active  = (state == ST_QUAL1) | (state == ST_QUAL2) | (state == ST_FAST1) |
                   (state == ST_FAST2) | (state == ST_MAINT);
    wire maint_tsc = (state == ST_MAINT) && algo == charge_pkg::ALGO_TWO_STEP_CURRENT;
    wire next_gate = (maint_tsc ? pulse_on_phase :
                      (state == ST_MAINT && pulsed) ? maint_on : active) & pwm_gate;
    charge_pkg::reg_type   next_mode;
    charge_pkg::level_type next_vlevel;
    charge_pkg::cur_type   next_clevel;
    assign next_mode =
        (state == ST_QUAL1 || state == ST_FAST2) ? charge_pkg::REG_VOLTAGE :
        (state == ST_QUAL2 || state == ST_FAST1) ? charge_pkg::REG_CURRENT :
        (state != ST_MAINT) ? charge_pkg::REG_OFF :
        (algo == charge_pkg::ALGO_TWO_STEP_VOLTAGE) ? charge_pkg::REG_VOLTAGE :
        charge_pkg::REG_PULSE;
    assign next_vlevel = (state == ST_QUAL1) ? charge_pkg::LEVEL_FLOAT_PLUS :
                         (state == ST_FAST2) ? charge_pkg::LEVEL_BULK :
                                               charge_pkg::LEVEL_FLOAT;
    assign next_clevel = (state == ST_QUAL2) ? charge_pkg::CUR_COND :
                         maint_tsc ? charge_pkg::CUR_FLOAT_AVG : charge_pkg::CUR_MAX;

    // ----------------------------------------
    // Lamp decode
    // ----------------------------------------
    wire show_qual  = (state == ST_START) | (state == ST_QUAL1) | (state == ST_QUAL2);
    wire show_fast  = (state == ST_FAST1) | (state == ST_FAST2) |
                      (state == ST_MAINT && pulsed && maint_on);
    wire show_maint = (state == ST_MAINT) & ~(pulsed & maint_on);
    wire fast_volt  = (state == ST_FAST2);
    wire m1 = (disp == charge_pkg::DISP_MODE_1);
    wire m2 = (disp == charge_pkg::DISP_MODE_2);
    wire held = (state == ST_PENDING) | ((state == ST_FAULT) & present);
    wire l1_live = m1 ? ((show_qual & flash) | show_fast) :
                   m2 ? (show_qual | show_maint) :
                        ((show_qual & flash) | (show_fast & fast_volt) | show_maint);
    wire l2_live = m1 ? show_maint :
                   m2 ? (show_qual | show_fast) :
                        ((show_qual & flash) | show_fast);
    wire l1 = (state == ST_FAULT && !present) ? 1'b0 : held ? lamp_hold_1 : l1_live;
    wire l2 = (state == ST_FAULT && !present) ? 1'b0 : held ? lamp_hold_2 : l2_live;
    wire l3 = (state == ST_FAULT) | ((state == ST_PENDING) & flash);
    wire blank = (blank_cnt != 32'h0000_0000);

    // ----------------------------------------
    // Output registers
    // ----------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            current_gate  <= 1'b0;
            reg_mode      <= charge_pkg::REG_OFF;
            voltage_level <= charge_pkg::LEVEL_FLOAT;
            current_level <= charge_pkg::CUR_MAX;
            lamp_hold_1   <= 1'b0;
            lamp_hold_2   <= 1'b0;
            status_lamp_1 <= 1'b0;
            status_lamp_2 <= 1'b0;
            status_lamp_3 <= 1'b0;
            lamp_enable_n <= 1'b1;
        end else begin
            current_gate  <= next_gate;
            reg_mode      <= next_mode;
            voltage_level <= next_vlevel;
            current_level <= next_clevel;
            lamp_hold_1   <= l1;
            lamp_hold_2   <= l2;
            status_lamp_1 <= ~blank & l1;
            status_lamp_2 <= ~blank & l2;
            status_lamp_3 <= ~blank & l3;
            lamp_enable_n <= blank;
        end
    end
endmodule // charge_cycle_sequencer
`default_nettype wire

//--- rtl/charge_pkg.sv
// Purpose: Types shared by the charge cycle sequencer.
// Assumes: Nothing beyond the header of constants.
// Notes:   Holds types only.
package charge_pkg;
    typedef enum logic [1:0] {
        ALGO_TWO_STEP_VOLTAGE,
        ALGO_TWO_STEP_CURRENT,
        ALGO_PULSED_CURRENT
    } algo_type;
    typedef enum logic [1:0] {
        DISP_MODE_1,
        DISP_MODE_2,
        DISP_MODE_3
    } disp_type;
    typedef enum logic [1:0] {
        REG_OFF,
        REG_CURRENT,
        REG_VOLTAGE,
        REG_PULSE
    } reg_type;
    typedef enum logic [1:0] {
        LEVEL_FLOAT,
        LEVEL_FLOAT_PLUS,
        LEVEL_BULK
    } level_type;
    typedef enum logic [1:0] {
        CUR_MAX,
        CUR_COND,
        CUR_FLOAT_AVG
    } cur_type;
endpackage

//--- rtl/sync_flags.sv
// Purpose: Two-stage synchroniser for a bundle of asynchronous flags.
// Assumes: Each bit is an independent level.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module sync_flags #(
    parameter int WIDTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage_one;

    // ----------------------------------------
    // Synchroniser stages
    // ----------------------------------------
    // Two flops per bit keep metastability away from the state machine.
    always_ff @(posedge clk) begin
        if (rst) begin
            stage_one <= '0;
            sync_out  <= '0;
        end else begin
            stage_one <= async_in;
            sync_out  <= stage_one;
        end
    end
endmodule // sync_flags
`default_nettype wire

//--- sim/charge_cycle_sequencer_monitor.sv
// Purpose: Port assertions for the charge cycle sequencer.
// Assumes: Flags reach the outputs within four edges.
// Notes:   Bound at the foot.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer_monitor #(
    parameter int QUAL1_TIMEOUT = 20
) (
    input wire logic       clk,
    input wire logic       rst,
    input wire logic       supply_valid,
    input wire logic       above_low_cutoff,
    input wire logic       below_high_cutoff,
    input wire logic       temp_in_range,
    input wire logic       current_gate,
    input wire logic [1:0] reg_mode,
    input wire logic [1:0] voltage_level,
    input wire logic [1:0] current_level,
    input wire logic       status_lamp_1,
    input wire logic       status_lamp_2,
    input wire logic       status_lamp_3,
    input wire logic       lamp_enable_n
);
    // ----
    // Helpers
    // ----
    localparam int Q1_MAX = QUAL1_TIMEOUT + 3;
    int q1_cnt;
    // Phase views; the slack on the limit covers flag and output latency.
    wire logic present = above_low_cutoff && below_high_cutoff;
    wire logic in_q1 = reg_mode == charge_pkg::REG_VOLTAGE
                       && voltage_level == charge_pkg::LEVEL_FLOAT_PLUS;
    wire logic in_q2 = reg_mode == charge_pkg::REG_CURRENT
                       && current_level == charge_pkg::CUR_COND;
    // Counts cycles in test one, so a timeout that never fires shows up.
    always_ff @(posedge clk)
        q1_cnt <= (rst || !in_q1) ? 0 : q1_cnt + 1;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence inserted;
        $rose(above_low_cutoff) && below_high_cutoff;
    endsequence
    sequence insert_ok;
        inserted ##0 (temp_in_range && supply_valid);
    endsequence
    // ----
    // Assertions
    // ----
    reset_clears_a: assert property (disable iff (1'b0) rst |=> !current_gate
        && lamp_enable_n && reg_mode == charge_pkg::REG_OFF) else $error("reset left outputs");
    absent_fault_a: assert property ((!present)[*6] |-> !current_gate && (lamp_enable_n
        || (status_lamp_3 && !status_lamp_1 && !status_lamp_2))) else $error("absent lamps");
    temp_inhibit_a: assert property ((!temp_in_range)[*5] |-> !current_gate)
        else $error("gate on with bad temperature");
    gate_needs_reg_a: assert property (current_gate |-> reg_mode != charge_pkg::REG_OFF)
        else $error("gate on without regulation");
    qual_entry_a: assert property (insert_ok |-> ##[2:7] in_q1)
        else $error("test one not entered");
    blank_latch_a: assert property (inserted |-> ##[2:5] lamp_enable_n[*6])
        else $error("lamps not blanked");
    qual_limit_a: assert property (q1_cnt <= Q1_MAX)
        else $error("test one overran");
    holdoff_keep_a: assert property ($rose(in_q2) |-> in_q2[*4])
        else $error("test two left in hold-off");
    pend_hold_a: assert property ((!temp_in_range && present)[*7] |->
        $stable(status_lamp_1) && $stable(status_lamp_2)) else $error("lamps moved");
endmodule // charge_cycle_sequencer_monitor
bind charge_cycle_sequencer charge_cycle_sequencer_monitor #(.QUAL1_TIMEOUT(QUAL1_TIMEOUT)) u_mon (
    .clk, .rst, .supply_valid, .above_low_cutoff, .below_high_cutoff, .temp_in_range,
    .current_gate, .reg_mode, .voltage_level, .current_level, .status_lamp_1,
    .status_lamp_2, .status_lamp_3, .lamp_enable_n);
`default_nettype wire

//--- sim/charge_cycle_sequencer_tb_top.sv
// Purpose: Self-checking bench for the charge cycle sequencer.
// Assumes: Shortened counts.
// Notes:   Outputs are packed into nibbles so one compare serves all.
`timescale 1ns/1ps
`default_nettype none
module charge_cycle_sequencer_tb_top;
    // ----
    // Stimulus and wiring
    // ----
    logic clk = 1'b0, rst = 1'b1, supply_valid = 1'b1, present = 1'b0, temp_ok = 1'b1;
    logic algo_select_a = 1'b0, algo_select_b = 1'b0;
    logic display_select_high = 1'b0, display_select_low = 1'b0;
    logic open_cell = 1'b0, charged = 1'b0, tapered = 1'b0;
    int   error_cnt = 0, n_tests = 0;
    wire logic above_low_cutoff, below_high_cutoff, temp_in_range, current_at_cond;
    wire logic cell_at_float, batt_at_bulk, batt_at_float, current_at_min, second_diff_trip;
    wire logic pwm_gate, current_gate, status_lamp_1, status_lamp_2, status_lamp_3;
    wire logic lamp_enable_n;
    logic [1:0] reg_mode, voltage_level, current_level;
    always #20 clk = ~clk;
    charge_cycle_sequencer #(.QUAL1_TIMEOUT(20), .QUAL2_TIMEOUT(20), .HOLDOFF(5),
        .FLASH_HALF(4), .BLANK_TIME(8), .PULSE_PERIOD(10), .PULSE_ON(3)) DUT (
        .clk, .rst, .supply_valid, .above_low_cutoff, .below_high_cutoff, .temp_in_range,
        .current_at_cond, .cell_at_float, .batt_at_bulk, .batt_at_float, .current_at_min,
        .second_diff_trip, .pwm_gate, .algo_select_a, .algo_select_b, .display_select_high,
        .display_select_low, .current_gate, .reg_mode, .voltage_level, .current_level,
        .status_lamp_1, .status_lamp_2, .status_lamp_3, .lamp_enable_n);
    charge_env_model u_model (.clk, .reg_mode, .present, .temp_ok, .open_cell, .charged,
        .tapered, .above_low_cutoff, .below_high_cutoff, .temp_in_range, .current_at_cond,
        .cell_at_float, .batt_at_bulk, .batt_at_float, .current_at_min, .second_diff_trip,
        .pwm_gate);
    // ----
    // Tasks
    // ----
    task automatic chk(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // View 0 regulation and level, 1 regulation and current, 2 lamps, 3 gate state.
    function automatic logic [3:0] view(input int sel);
        case (sel)
            0: return {reg_mode, voltage_level};
            1: return {reg_mode, current_level};
            2: return {lamp_enable_n, status_lamp_3, status_lamp_2, status_lamp_1};
            default: return {1'b0, current_gate, status_lamp_3, lamp_enable_n};
        endcase
    endfunction
    // Bounded wait for a view; running out ends the run.
    task automatic step(input string what, input int sel, input logic [3:0] exp);
        int k;
        for (k = 0; k < 300 && view(sel) !== exp; k++) @(negedge clk);
        chk(what, view(sel), exp);
        if (k == 300) summarize();
    endtask
    // Pull, set pins, reinsert.
    task automatic insert(input logic a, b, dh, dl, open);
        @(posedge clk);
        present <= 1'b0;
        repeat (6) @(posedge clk);
        {algo_select_a, algo_select_b, display_select_high, display_select_low} <= {a, b, dh, dl};
        {open_cell, charged, tapered} <= {open, 2'b00};
        @(posedge clk);
        present <= 1'b1;
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // ----
    // Tests
    // ----
    initial begin
        logic [7:0] s;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        step("absent lamps", 2, 4'b0100);
        insert(1'b0, 1'b1, 1'b0, 1'b1, 1'b0);
        step("test one", 0, {charge_pkg::REG_VOLTAGE, charge_pkg::LEVEL_FLOAT_PLUS});
        step("test two", 1, {charge_pkg::REG_CURRENT, charge_pkg::CUR_COND});
        step("phase one", 1, {charge_pkg::REG_CURRENT, charge_pkg::CUR_MAX});
        step("fast lamps", 2, 4'b0001);
        charged <= 1'b1;
        step("phase two", 0, {charge_pkg::REG_VOLTAGE, charge_pkg::LEVEL_BULK});
        tapered <= 1'b1;
        step("float", 0, {charge_pkg::REG_VOLTAGE, charge_pkg::LEVEL_FLOAT});
        step("float lamps", 2, 4'b0010);
        $display("test two-step voltage done");
        temp_ok <= 1'b0;
        repeat (6) @(negedge clk);
        chk("pending gate", {3'b000, current_gate}, 4'b0000);
        chk("pending hold", {2'b00, status_lamp_2, status_lamp_1}, 4'b0010);
        s = {8{status_lamp_3}};
        for (int k = 0; k < 20 && status_lamp_3 === s[0]; k++) @(negedge clk);
        for (int k = 0; k < 8; k++) begin
            s = {s[6:0], status_lamp_3};
            @(negedge clk);
        end
        chk("flash first half", s[7:4], {4{s[7]}});
        chk("flash second half", s[3:0], {4{~s[7]}});
        @(posedge clk);
        temp_ok <= 1'b1;
        repeat (6) @(negedge clk);
        chk("resume", view(0), {charge_pkg::REG_VOLTAGE, charge_pkg::LEVEL_FLOAT});
        $display("test pending done");
        insert(1'b0, 1'b1, 1'b0, 1'b1, 1'b1);
        step("open one", 0, {charge_pkg::REG_VOLTAGE, charge_pkg::LEVEL_FLOAT_PLUS});
        step("open cell fault", 3, 4'b0010);
        temp_ok <= 1'b0;
        repeat (8) @(negedge clk);
        chk("fault ignores temp", view(3), 4'b0010);
        {temp_ok, open_cell, supply_valid} <= 3'b100;
        repeat (4) @(negedge clk);
        supply_valid <= 1'b1;
        step("restart", 0, {charge_pkg::REG_VOLTAGE, charge_pkg::LEVEL_FLOAT_PLUS});
        $display("test fault done");
        insert(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
        step("current fast lamps", 2, 4'b0010);
        tapered <= 1'b1;
        step("pulse upkeep", 1, {charge_pkg::REG_PULSE, charge_pkg::CUR_FLOAT_AVG});
        step("mode two upkeep", 2, 4'b0001);
        insert(1'b1, 1'b1, 1'b0, 1'b0, 1'b0);
        step("pulsed fast lamps", 2, 4'b0010);
        charged <= 1'b1;
        step("pulsed off lamps", 2, 4'b0001);
        charged <= 1'b0;
        step("pulsed on lamps", 2, 4'b0010);
        insert(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        step("mode three current", 2, 4'b0010);
        charged <= 1'b1;
        step("mode three voltage", 2, 4'b0011);
        $display("test algorithms done");
        summarize();
    end
endmodule // charge_cycle_sequencer_tb_top
`default_nettype wire

//--- sim/charge_env_model.sv
// Purpose: Battery, thermistor and comparator stand-in.
// Assumes: The bench sets the knobs.
// Notes:   Flags are registered to mimic comparator settling.
`timescale 1ns/1ps
`default_nettype none
module charge_env_model (
    input  wire logic       clk,
    input  wire logic [1:0] reg_mode,
    input  wire logic       present,
    input  wire logic       temp_ok,
    input  wire logic       open_cell,
    input  wire logic       charged,
    input  wire logic       tapered,
    output logic            above_low_cutoff,
    output logic            below_high_cutoff,
    output logic            temp_in_range,
    output logic            current_at_cond,
    output logic            cell_at_float,
    output logic            batt_at_bulk,
    output logic            batt_at_float,
    output logic            current_at_min,
    output logic            second_diff_trip,
    output logic            pwm_gate
);
    // ----
    // Comparators
    // ----
    logic [1:0] pwm_cnt = 2'b00;
    logic [8:0] flags   = 9'h000;
    // An open cell never draws current, so test one must time out.
    always @(posedge clk) begin
        pwm_cnt <= pwm_cnt + 2'b01;
        flags   <= {present, present, temp_ok, !open_cell && reg_mode != charge_pkg::REG_OFF,
                    !open_cell, charged, charged, tapered, tapered};
    end
    assign {above_low_cutoff, below_high_cutoff, temp_in_range, current_at_cond,
            cell_at_float, batt_at_bulk, batt_at_float, current_at_min, second_diff_trip} = flags;
    // Three of four cycles on, so the gate is seen both ways.
    assign pwm_gate = pwm_cnt != 2'b00;
endmodule // charge_env_model
`default_nettype wire
